// *** adc_link_chk.sv ***
// protocol checker watching the serial link between converter and host
module adc_link_chk (
	// clock and reset
	input  wire logic CLK_I,
	input  wire logic ARST_N_I,
	// link signals
	input  wire logic sclk,
	input  wire logic cs_n,
	input  wire logic mosi,
	input  wire logic miso,
	input  wire logic result_ready_n
);
	timeunit 1ns;
	timeprecision 1ps;

	logic       sclk_q;
	logic [5:0] rises;
	logic [7:0] low_cnt;

	// ==========================================================
	// helper counters
	// clock rises and cycles per frame, cleared while deselected
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			sclk_q  <= 1'b0;
			rises   <= 6'h00;
			low_cnt <= 8'h00;
		end else begin
			sclk_q  <= sclk;
			rises   <= cs_n ? 6'h00 : rises + {5'h00, sclk & ~sclk_q};
			low_cnt <= cs_n ? 8'h00 : low_cnt + 8'h01;
		end
	end

	// ==========================================================
	// assertions
	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (!ARST_N_I);

	a_sclk_idle_low: assert property (cs_n |-> !sclk)
		else $error("serial clock high outside a frame");
	a_mosi_idle_low: assert property (cs_n |-> !mosi)
		else $error("command line high outside a frame");
	a_miso_idle_low: assert property (cs_n && $past(cs_n) |-> !miso)
		else $error("result line high outside a frame");
	a_sclk_high_half: assert property ($rose(sclk) |=> sclk ##1 !sclk)
		else $error("serial clock high phase not two cycles");
	a_sclk_low_half: assert property ($fell(sclk) |=> !sclk ##1 (sclk || cs_n))
		else $error("serial clock low phase not two cycles");
	a_select_lead: assert property ($fell(cs_n) |-> !sclk[*2] ##1 sclk)
		else $error("first clock rise not a half period after select");
	a_ready_clears: assert property ($fell(cs_n) |=> result_ready_n)
		else $error("ready flag not cleared after select");
	a_miso_hold: assert property ($fell(sclk) |-> $stable(miso)[*2])
		else $error("result bit moved around the sampling fall");
	a_frame_bits: assert property ($rose(cs_n) |-> rises inside {6'h08, 6'h10, 6'h18, 6'h20})
		else $error("frame carried an odd number of clocks");
	a_frame_bound: assert property (!cs_n |-> low_cnt < 8'h8c)
		else $error("frame lasted too long");
endmodule

// *** adc_link_pkg.sv ***
// shared constants, command codes and helpers of the converter serial link
package adc_link_pkg;

	// ==========================================================
	// clocks and timing
	localparam int CLK_HZ        = 250_000_000;
	localparam int XTAL_HZ       = 8_000_000;
	// converter clock period in system cycles, rounded down
	localparam int XTAL_DIV      = CLK_HZ / XTAL_HZ;
	localparam int SCLK_MIN_HZ   = 8_000_000;
	// longest legal half period of the serial clock, rounded down
	localparam int SCLK_HALF_MAX = CLK_HZ / (2 * SCLK_MIN_HZ);

	// ==========================================================
	// strap patterns
	localparam logic [1:0] FILT_WIDEBAND2 = 2'h1;
	localparam logic [1:0] OSR_SEL_RESET  = 2'h1;
	localparam logic       HR_RESET       = 1'h1;
	localparam logic       LDO_RESET_N    = 1'h0;
	// wideband 2 passband edge, as a fraction of the word rate
	localparam int PASSBAND_NUM = 4;
	localparam int PASSBAND_DEN = 10;

	// ==========================================================
	// configuration register and commands
	localparam logic [7:0] CFG_ADDR      = 8'h01;
	localparam int         CFG_SD_BIT    = 1;
	localparam logic [7:0] CFG_RESET     = 8'h00;
	localparam logic [7:0] CMD_NOP       = 8'h00;
	localparam logic [7:0] CMD_START     = 8'h08;
	localparam logic [7:0] CMD_STOP      = 8'h0a;
	localparam logic [7:0] CMD_WREG_BASE = 8'h40;
	localparam logic [7:0] CMD_WCFG      = CMD_WREG_BASE | CFG_ADDR;

	// ==========================================================
	// word layout
	localparam int         DATA_BITS   = 24;
	localparam int         STATUS_BITS = 8;
	localparam int         WORD_BITS   = 32;
	localparam int         CMD_BITS    = 8;
	localparam logic [5:0] LEN_DATA    = 6'h18;
	localparam logic [5:0] LEN_FULL    = 6'h20;
	localparam logic [5:0] LEN_CMD     = 6'h08;
	localparam logic [5:0] LEN_CMD_ARG = 6'h10;

	// oversampling ratio for a strap pattern
	function automatic logic [8:0] osr_value(input logic [1:0] sel);
		case (sel)
			2'h0:    osr_value = 9'h020;
			2'h1:    osr_value = 9'h040;
			2'h2:    osr_value = 9'h080;
			default: osr_value = 9'h100;
		endcase
	endfunction

	// bits per result for a status-disable setting
	function automatic logic [5:0] word_len(input logic sd);
		word_len = sd ? LEN_DATA : LEN_FULL;
	endfunction

endpackage

// *** adc_readout_device.sv ***
// converter end: strap decode, conversion timing and serial readout

// Function
// - filter strap 01 selects wideband filter two
// - start pin low: start command begins conversion
// - ratio straps pick ratio, 01 gives 64
// - resolution strap low means low power
// - regulator strap low enables internal regulator
// - word rate is crystal clock over ratio
// - status disabled: words carry 24 data bits
// - status enabled: words carry 32 bits
// - sample continuously, flag each result, no reads
// - shift MSB first on serial clock rises
// - host clock at least 24 times rate
// - host clock 8 MHz at top rate
// - host waits for ready before clocking out
module adc_readout_device #(
	parameter int XTAL_DIV = adc_link_pkg::XTAL_DIV
) (
	// clock and reset
	input  wire logic        CLK_I,
	input  wire logic        ARST_N_I,
	// link to the host
	adc_spi_if.device        LINK,
	// converter result from the analog side
	input  wire logic [23:0] SAMPLE_I,
	// decoded configuration and activity
	output logic             SAMPLE_TAKE_O,
	output logic             RUNNING_O,
	output logic             WIDEBAND2_O,
	output logic [8:0]       OSR_O,
	output logic             LOW_POWER_O,
	output logic             REGULATOR_ON_O,
	output logic             STATUS_DISABLE_O
);

	// divider width must hold the full crystal period count
	localparam int DW = $clog2(XTAL_DIV + 1);

	// ==========================================================
	// state
	// one record of all state, registered as a whole
	typedef struct packed {
		logic          sclk_q;
		logic          cs_q;
		logic          started;
		logic [7:0]    cfg;
		logic [DW-1:0] div_cnt;
		logic [8:0]    osr_cnt;
		logic [31:0]   word;
		logic [31:0]   shift;
		logic          rdy_n;
		logic          miso;
		logic [5:0]    rx_cnt;
		logic [7:0]    rx_sh;
		logic [7:0]    opcode;
		logic          take;
		logic          wideband2;
		logic [8:0]    oversampling_ratio;
		logic          low_power;
		logic          reg_on;
	} dev_state_t;

	dev_state_t st_reg;
	dev_state_t st_next;

	// combinational helpers, derived from registered state or pins
	logic       running;
	logic       sclk_rise;
	logic       sclk_fall;
	logic       cs_fall;
	logic       frame;
	logic       sd;
	logic [7:0] rx_byte;
	logic [7:0] status;

	// edges of the link, pins taken as synchronous
	// each pin is compared with its own copy, so an edge lasts one cycle
	assign sclk_rise = LINK.sclk & ~st_reg.sclk_q;
	assign sclk_fall = ~LINK.sclk & st_reg.sclk_q;
	assign cs_fall   = ~LINK.cs_n & st_reg.cs_q;
	assign frame     = ~LINK.cs_n;
	assign sd        = st_reg.cfg[adc_link_pkg::CFG_SD_BIT];
	assign rx_byte   = {st_reg.rx_sh[6:0], LINK.mosi};

	// pin level or start command
	// the latch output does not show the pin, only the command state
	assign running = LINK.start_pin | st_reg.started;

	// status byte mirrors the decoded straps
	// trade-off: the ratio field is the raw strap, not the decoded ratio
	assign status = {running, st_reg.wideband2, LINK.oversample_ratio_select,
		st_reg.low_power, st_reg.reg_on, sd, 1'b0};

	// ==========================================================
	// next-state logic
	always_comb begin
		st_next        = st_reg;
		st_next.sclk_q = LINK.sclk;
		st_next.cs_q   = LINK.cs_n;
		st_next.take   = 1'b0;

		st_next.wideband2 = (LINK.filter_select == adc_link_pkg::FILT_WIDEBAND2);
		st_next.oversampling_ratio       = adc_link_pkg::osr_value(LINK.oversample_ratio_select);
		st_next.low_power = ~LINK.high_resolution_select;
		st_next.reg_on    = ~LINK.internal_regulator_enable_n;

		// command receiver: mosi taken on falling serial clock
		// byte 0 is the opcode, byte 1 its argument, later bytes are ignored
		if (!frame) begin
			st_next.rx_cnt = '0;
		end else if (sclk_fall) begin
			st_next.rx_sh  = rx_byte;
			st_next.rx_cnt = st_reg.rx_cnt + 6'h01;
			if (st_reg.rx_cnt[2:0] == 3'h7) begin
				if (st_reg.rx_cnt[5:3] == 3'h0) begin
					st_next.opcode = rx_byte;
					if (rx_byte == adc_link_pkg::CMD_START) begin
						st_next.started = 1'b1;
					end
					if (rx_byte == adc_link_pkg::CMD_STOP) begin
						st_next.started = 1'b0;
					end
				end else if (st_reg.rx_cnt[5:3] == 3'h1 &&
					st_reg.opcode == adc_link_pkg::CMD_WCFG) begin
					st_next.cfg = rx_byte;
				end
			end
		end

		// snapshot at frame start, then MSB out per rise
		if (cs_fall) begin
			// format follows the setting at readout, so a result formed
			// just before a length change still matches the host's count
			if (sd) begin
				// data only, low byte left clear
				st_next.shift = st_reg.word;
			end else begin
				st_next.shift = {st_reg.word[31:8], status};
			end
			st_next.rdy_n = 1'b1;
			st_next.miso  = 1'b0;
		end else if (frame && sclk_rise) begin
			st_next.miso  = st_reg.shift[31];
			st_next.shift = {st_reg.shift[30:0], 1'b0};
		end else if (!frame) begin
			st_next.miso  = 1'b0;
		end

		// crystal tick, then count the ratio
		if (!running) begin
			st_next.div_cnt = '0;
			st_next.osr_cnt = '0;
		end else if (st_reg.div_cnt == DW'(XTAL_DIV - 1)) begin
			st_next.div_cnt = '0;
			// a ratio lowered mid-count must not let the counter wrap
			if (st_reg.osr_cnt >= st_reg.oversampling_ratio - 9'h001) begin
				st_next.osr_cnt = '0;
				// new result, ready flag set wins
				st_next.take    = 1'b1;
				st_next.rdy_n   = 1'b0;
				// only the data is kept here, status joins it at readout
				st_next.word    = {SAMPLE_I, 8'h00};
			end else begin
				st_next.osr_cnt = st_reg.osr_cnt + 9'h001;
			end
		end else begin
			st_next.div_cnt = st_reg.div_cnt + DW'(1);
		end
	end

	// ==========================================================
	// state register
	// the ratio resets to its decoded default of 64 and low_power to its default of 0; wideband2 and reg_on reset low
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			st_reg           <= '0;
			st_reg.cs_q      <= 1'b1;
			st_reg.cfg       <= adc_link_pkg::CFG_RESET;
			st_reg.rdy_n     <= 1'b1;
			st_reg.oversampling_ratio       <= 9'h040;
			st_reg.wideband2 <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// outputs, all from flops
	// miso rests low outside frames so a shared bus sees no stale bit
	assign LINK.miso           = st_reg.miso;
	assign LINK.result_ready_n = st_reg.rdy_n;
	assign SAMPLE_TAKE_O       = st_reg.take;
	assign RUNNING_O           = st_reg.started;
	assign WIDEBAND2_O         = st_reg.wideband2;
	assign OSR_O               = st_reg.oversampling_ratio;
	assign LOW_POWER_O         = st_reg.low_power;
	assign REGULATOR_ON_O      = st_reg.reg_on;
	assign STATUS_DISABLE_O    = st_reg.cfg[adc_link_pkg::CFG_SD_BIT];

endmodule

// *** adc_readout_host.sv ***
// host end: drives straps, sends commands and reads result words
module adc_readout_host #(
	parameter int SCLK_HALF = 2
) (
	// clock and reset
	input  wire logic        CLK_I,
	input  wire logic        ARST_N_I,
	// link to the converter
	adc_spi_if.host          LINK,
	// strap levels wanted by the user
	input  wire logic [1:0]  FILTER_SEL_I,
	input  wire logic [1:0]  OSR_SEL_I,
	input  wire logic        HR_SEL_I,
	input  wire logic        LDO_EN_N_I,
	input  wire logic        START_PIN_I,
	// command requests, one-cycle pulses
	input  wire logic        START_CMD_I,
	input  wire logic        STOP_CMD_I,
	input  wire logic        CFG_WR_I,
	input  wire logic        CFG_SD_I,
	output logic             CMD_BUSY_O,
	// result stream
	output logic [31:0]      WORD_O,
	output logic             WORD_LEN32_O,
	output logic             WORD_VALID_O,
	input  wire logic        WORD_READY_I
);

	// gray coded along idle, low, high, done
	typedef enum logic [1:0] {
		S_IDLE = 2'h0,
		S_LOW  = 2'h1,
		S_HIGH = 2'h3,
		S_DONE = 2'h2
	} hst_phase_t;

	// ==========================================================
	// state, including the two-entry result buffer
	typedef struct packed {
		hst_phase_t       phase;
		logic [7:0]       hc;
		logic [5:0]       bit_cnt;
		logic [5:0]       nbits;
		logic             is_read;
		logic             is_cfg;
		logic [31:0]      tx;
		logic [31:0]      rx;
		logic             sclk;
		logic             cs_n;
		logic             mosi;
		logic             p_start;
		logic             p_stop;
		logic             p_cfg;
		logic             cfg_val;
		logic             sd_cur;
		logic [1:0]       cnt;
		logic [1:0][32:0] mem;
		logic [7:0]       straps;
		logic             busy;
		logic             valid;
	} hst_state_t;

	hst_state_t st_reg;
	hst_state_t st_next;
	logic       half_done;
	logic       pop;
	logic [32:0] rd_word;

	assign half_done = (st_reg.hc == 8'(SCLK_HALF - 1));
	assign pop       = WORD_READY_I & (st_reg.cnt != 2'h0);
	// 24-bit words come out right aligned
	assign rd_word   = {~st_reg.sd_cur, st_reg.sd_cur ?
		{8'h00, st_reg.rx[22:0], LINK.miso} : {st_reg.rx[30:0], LINK.miso}};

	// ==========================================================
	// next-state logic
	always_comb begin
		st_next        = st_reg;
		st_next.straps = {FILTER_SEL_I, OSR_SEL_I, HR_SEL_I, LDO_EN_N_I, START_PIN_I, 1'b0};

		// buffer drain side
		if (pop) begin
			st_next.mem[0] = st_reg.mem[1];
			st_next.cnt    = st_reg.cnt - 2'h1;
		end

		case (st_reg.phase)
			S_IDLE: begin
				st_next.hc      = '0;
				st_next.bit_cnt = '0;
				st_next.is_read = 1'b0;
				st_next.is_cfg  = 1'b0;
				// start or stop command, issued ahead of config writes and reads
				if (st_reg.p_start || st_reg.p_stop) begin
					st_next.tx      = {st_reg.p_start ? adc_link_pkg::CMD_START :
						adc_link_pkg::CMD_STOP, 24'h000000};
					st_next.nbits   = adc_link_pkg::LEN_CMD;
					st_next.p_start = 1'b0;
					st_next.p_stop  = st_reg.p_start & st_reg.p_stop;
					st_next.cs_n    = 1'b0;
					st_next.phase   = S_LOW;
				end else if (st_reg.p_cfg) begin
					st_next.tx     = {adc_link_pkg::CMD_WCFG,
						6'h00, st_reg.cfg_val, 1'b0, 16'h0000};
					st_next.nbits  = adc_link_pkg::LEN_CMD_ARG;
					st_next.p_cfg  = 1'b0;
					st_next.is_cfg = 1'b1;
					st_next.cs_n   = 1'b0;
					st_next.phase  = S_LOW;
				// read only after ready seen, and with room
				end else if (!LINK.result_ready_n && st_reg.cnt != 2'h2) begin
					st_next.tx      = '0;
					st_next.nbits   = adc_link_pkg::word_len(st_reg.sd_cur);
					st_next.is_read = 1'b1;
					st_next.cs_n    = 1'b0;
					st_next.phase   = S_LOW;
				end
			end
			// half period bounds the serial clock rate
			S_LOW: begin
				st_next.hc = st_reg.hc + 8'h01;
				if (half_done) begin
					st_next.hc    = '0;
					st_next.sclk  = 1'b1;
					st_next.mosi  = st_reg.tx[31];
					st_next.tx    = {st_reg.tx[30:0], 1'b0};
					st_next.phase = S_HIGH;
				end
			end
			S_HIGH: begin
				st_next.hc = st_reg.hc + 8'h01;
				if (half_done) begin
					st_next.hc      = '0;
					st_next.sclk    = 1'b0;
					st_next.rx      = {st_reg.rx[30:0], LINK.miso};
					st_next.bit_cnt = st_reg.bit_cnt + 6'h01;
					st_next.phase   = (st_reg.bit_cnt + 6'h01 == st_reg.nbits) ? S_DONE : S_LOW;
					if (st_reg.bit_cnt + 6'h01 == st_reg.nbits && st_reg.is_read) begin
						st_next.mem[st_next.cnt[0]] = rd_word;
						st_next.cnt = st_next.cnt + 2'h1;
					end
				end
			end
			S_DONE: begin
				st_next.hc = st_reg.hc + 8'h01;
				if (half_done) begin
					st_next.cs_n  = 1'b1;
					st_next.mosi  = 1'b0;
					st_next.phase = S_IDLE;
					if (st_reg.is_cfg) begin
						st_next.sd_cur = st_reg.cfg_val;
					end
				end
			end
			default: begin
				st_next.phase = S_IDLE;
				st_next.cs_n  = 1'b1;
				st_next.sclk  = 1'b0;
			end
		endcase

		// user requests, set wins over the clear above
		if (START_CMD_I) begin
			st_next.p_start = 1'b1;
		end
		if (STOP_CMD_I) begin
			st_next.p_stop = 1'b1;
		end
		if (CFG_WR_I) begin
			st_next.p_cfg   = 1'b1;
			st_next.cfg_val = CFG_SD_I;
		end

		// status outputs registered so they come straight from flops
		st_next.busy  = st_next.p_start | st_next.p_stop | st_next.p_cfg;
		st_next.valid = (st_next.cnt != 2'h0);
	end

	// ==========================================================
	// state register
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			st_reg        <= '0;
			st_reg.phase  <= S_IDLE;
			st_reg.cs_n   <= 1'b1;
			st_reg.straps <= {adc_link_pkg::FILT_WIDEBAND2, adc_link_pkg::OSR_SEL_RESET,
				adc_link_pkg::HR_RESET, adc_link_pkg::LDO_RESET_N, 2'h0};
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// outputs, all from flops
	assign LINK.sclk                        = st_reg.sclk;
	assign LINK.cs_n                        = st_reg.cs_n;
	assign LINK.mosi                        = st_reg.mosi;
	assign LINK.filter_select               = st_reg.straps[7:6];
	assign LINK.oversample_ratio_select     = st_reg.straps[5:4];
	assign LINK.high_resolution_select      = st_reg.straps[3];
	assign LINK.internal_regulator_enable_n = st_reg.straps[2];
	assign LINK.start_pin                   = st_reg.straps[1];
	assign CMD_BUSY_O                       = st_reg.busy;
	assign WORD_O                           = st_reg.mem[0][31:0];
	assign WORD_LEN32_O                     = st_reg.mem[0][32];
	assign WORD_VALID_O                     = st_reg.valid;

endmodule

// *** adc_spi_if.sv ***
// serial link and strap pins between the converter and its host
interface adc_spi_if;
	// serial bus
	logic       sclk;
	logic       cs_n;
	logic       mosi;
	logic       miso;
	logic       result_ready_n;
	// strap pins
	logic [1:0] filter_select;
	logic [1:0] oversample_ratio_select;
	logic       high_resolution_select;
	logic       internal_regulator_enable_n;
	logic       start_pin;

	modport device (
		input  sclk, cs_n, mosi,
		input  filter_select, oversample_ratio_select,
		input  high_resolution_select, internal_regulator_enable_n, start_pin,
		output miso, result_ready_n
	);
	modport host (
		output sclk, cs_n, mosi,
		output filter_select, oversample_ratio_select,
		output high_resolution_select, internal_regulator_enable_n, start_pin,
		input  miso, result_ready_n
	);
endinterface

// *** tb.sv ***
// self-checking bench joining the converter end and the host end
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	// a short converter clock keeps result periods a few hundred cycles
	localparam int         XDIV   = 4;
	// running, wideband 2, ratio 01, full power, regulator on, status on
	localparam logic [7:0] ST_RUN = 8'hd4;

	// ==========================================================
	// signals
	logic        clk;
	logic        arst_n;
	logic [23:0] sample;
	logic [1:0]  filt_sel;
	logic [1:0]  osr_sel;
	logic        hr_sel;
	logic        ldo_en_n;
	logic        start_pin;
	logic        start_cmd;
	logic        stop_cmd;
	logic        cfg_wr;
	logic        cfg_sd;
	logic        word_ready;
	logic        take, running, wb2, low_pwr, reg_on, sd, busy, len32, valid;
	logic [8:0]  oversampling_ratio;
	logic [31:0] word;
	logic [31:0] wire_word;
	int          wire_bits;
	int          miscompares;
	int          n_compared;
	int          n;

	// ==========================================================
	// instances
	adc_spi_if i_adc_spi_if ();
	adc_readout_device #(.XTAL_DIV(XDIV)) i_adc_readout_device (
		.CLK_I(clk), .ARST_N_I(arst_n), .LINK(i_adc_spi_if.device), .SAMPLE_I(sample),
		.SAMPLE_TAKE_O(take), .RUNNING_O(running), .WIDEBAND2_O(wb2), .OSR_O(oversampling_ratio),
		.LOW_POWER_O(low_pwr), .REGULATOR_ON_O(reg_on), .STATUS_DISABLE_O(sd));
	adc_readout_host #(.SCLK_HALF(2)) i_adc_readout_host (
		.CLK_I(clk), .ARST_N_I(arst_n), .LINK(i_adc_spi_if.host), .FILTER_SEL_I(filt_sel),
		.OSR_SEL_I(osr_sel), .HR_SEL_I(hr_sel), .LDO_EN_N_I(ldo_en_n), .START_PIN_I(start_pin),
		.START_CMD_I(start_cmd), .STOP_CMD_I(stop_cmd), .CFG_WR_I(cfg_wr), .CFG_SD_I(cfg_sd),
		.CMD_BUSY_O(busy), .WORD_O(word), .WORD_LEN32_O(len32), .WORD_VALID_O(valid),
		.WORD_READY_I(word_ready));
	adc_link_chk i_adc_link_chk (
		.CLK_I(clk), .ARST_N_I(arst_n), .sclk(i_adc_spi_if.sclk), .cs_n(i_adc_spi_if.cs_n),
		.mosi(i_adc_spi_if.mosi), .miso(i_adc_spi_if.miso),
		.result_ready_n(i_adc_spi_if.result_ready_n));

	// free-running system clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// wire-side capture of result bits at each sampling fall
	always @(negedge i_adc_spi_if.cs_n) wire_bits = 0;
	always @(negedge i_adc_spi_if.sclk) begin
		if (!i_adc_spi_if.cs_n) begin
			wire_word = {wire_word[30:0], i_adc_spi_if.miso};
			wire_bits++;
		end
	end

	// ==========================================================
	// tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// bounded wait: 0 result pulse, 1 word in buffer, 2 commands taken, 3 deselected
	task automatic wait_for(input int what, output int cnt);
		for (cnt = 1; cnt < 4000; cnt++) begin
			@(negedge clk);
			if ((what == 0 && take) || (what == 1 && valid) || (what == 2 && !busy) ||
				(what == 3 && i_adc_spi_if.cs_n))
				return;
		end
		$display("FAIL wait %0d timed out", what);
		miscompares++;
		tally_and_finish();
	endtask

	// counts result pulses (0) or selected cycles (1) over k cycles
	task automatic count(input int what, input int k, output int c);
		c = 0;
		repeat (k) begin
			@(negedge clk);
			c += (what == 0) ? int'(take) : int'(!i_adc_spi_if.cs_n);
		end
	endtask

	task automatic pop(input int k);
		word_ready = 1'b1;
		repeat (k) @(negedge clk);
		word_ready = 1'b0;
	endtask

	// bits are {start, stop, config write, status disable}; buffer drains meanwhile
	task automatic send(input logic [3:0] bits);
		@(negedge clk);
		word_ready = 1'b1;
		{start_cmd, stop_cmd, cfg_wr, cfg_sd} = bits;
		@(negedge clk);
		{start_cmd, stop_cmd, cfg_wr} = 3'h0;
		// busy drops as the frame starts; the command acts only at its end
		wait_for(2, n);
		wait_for(3, n);
		word_ready = 1'b0;
	endtask

	// one fresh word from the buffer, checked there and on the wire
	task automatic read_word(input logic [31:0] exp, input logic exp32);
		wait_for(1, n);
		check("word", word, exp);
		check("word length flag", len32, exp32);
		check("wire bits", wire_bits, exp32 ? 32 : 24);
		check("wire word", exp32 ? wire_word : {8'h00, wire_word[23:0]}, exp);
		pop(1);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		{filt_sel, osr_sel, hr_sel, ldo_en_n, start_pin} = 7'b01_01_1_0_0;
		{start_cmd, stop_cmd, cfg_wr, cfg_sd, word_ready} = 5'h00;
		sample = 24'ha5c396;
		miscompares = 0;
		n_compared = 0;
		arst_n = 1'b0;
		repeat (3) @(negedge clk);
		arst_n = 1'b1;
		repeat (3) @(negedge clk);
		check("osr", oversampling_ratio, 9'h040);
		check("wideband2", wb2, 1'b1);
		check("low power", low_pwr, 1'b0);
		check("regulator", reg_on, 1'b1);
		check("status disable", sd, 1'b0);
		count(0, 600, n);
		check("idle results", n, 0);
		// each filter pattern, only 01 picks wideband 2
		for (int f = 0; f < 4; f++) begin
			filt_sel = 2'(f);
			repeat (3) @(negedge clk);
			check("wideband2", wb2, f == 1);
		end
		filt_sel = 2'h1;
		{hr_sel, ldo_en_n} = 2'b01;
		repeat (3) @(negedge clk);
		check("low power", low_pwr, 1'b1);
		check("regulator", reg_on, 1'b0);
		{hr_sel, ldo_en_n} = 2'b10;
		send(4'h8);
		check("running", running, 1'b1);
		read_word({sample, ST_RUN}, 1'b1);
		// length switches both ways; the host must realign each time
		for (int s = 1; s >= 0; s--) begin
			send({3'h1, s[0]});
			check("status disable", sd, s[0]);
			read_word(s[0] ? {8'h00, sample} : {sample, ST_RUN}, !s[0]);
		end
		// word period per ratio, measured after the change has settled
		for (int r = 0; r < 4; r++) begin
			osr_sel = 2'(r);
			repeat (3) @(negedge clk);
			check("osr", oversampling_ratio, 9'h020 << r);
			repeat (2) wait_for(0, n);
			wait_for(0, n);
			check("word period", n, XDIV * (32 << r));
		end
		// buffer full: the waiting result stays unread
		check("buffer full", valid, 1'b1);
		wait_for(0, n);
		repeat (2) @(negedge clk);
		check("ready held", i_adc_spi_if.result_ready_n, 1'b0);
		count(1, 300, n);
		check("reads while full", n, 0);
		pop(2);
		check("buffer empty", valid, 1'b0);
		osr_sel = 2'h1;
		send(4'h4);
		check("running", running, 1'b0);
		count(0, 1200, n);
		check("results after stop", n, 0);
		// start pin high converts without the command latch
		start_pin = 1'b1;
		wait_for(0, n);
		check("running", running, 1'b0);
		tally_and_finish();
	end
endmodule
